// ### design/wasm_pkg.sv
package wasm_pkg;

    localparam int WASM_BYTE_W = 8;
    localparam int WASM_WORD_W = 16;
    localparam int WASM_CNT_W = 4;
    localparam int WASM_WAIT_W = 4;

    // Execution time in CPU clocks, counted from issue to done
    localparam logic [3:0] WASM_CLK_ONE = 4'h1;
    localparam logic [3:0] WASM_CLK_TWO = 4'h2;
    localparam logic [3:0] WASM_CLK_THREE = 4'h3;
    localparam logic [3:0] WASM_CLK_FOUR = 4'h4;
    localparam logic [3:0] WASM_CLK_FIVE = 4'h5;
    // Fetch from internal RAM stretches to twice the count plus this
    localparam logic [4:0] WASM_RAM_FETCH_EXTRA = 5'h03;

    typedef enum logic [3:0] {
        WASM_OP_WORD_SUM,
        WASM_OP_WORD_DIFFERENCE,
        WASM_OP_WORD_COMPARE,
        WASM_OP_UNSIGNED_PRODUCT,
        WASM_OP_BYTE_PLUS_ONE,
        WASM_OP_BYTE_MINUS_ONE,
        WASM_OP_WORD_PLUS_ONE,
        WASM_OP_WORD_MINUS_ONE,
        WASM_OP_LOGICAL_RIGHT_BYTE,
        WASM_OP_LOGICAL_RIGHT_WORD,
        WASM_OP_LEFT_BYTE_SHIFT,
        WASM_OP_LEFT_WORD_SHIFT,
        WASM_OP_ARITH_RIGHT_BYTE,
        WASM_OP_ARITH_RIGHT_WORD
    } wasm_op_t;

    // Where the operand lives; sets the execution time
    typedef enum logic [2:0] {
        WASM_LOC_REG,
        WASM_LOC_DATA_MEM,
        WASM_LOC_PROG_MEM,
        WASM_LOC_SEG_DATA,
        WASM_LOC_SEG_PROG
    } wasm_loc_t;

    typedef struct packed {
        wasm_op_t op;
        wasm_loc_t loc;
        logic ram_fetch;
        logic [WASM_WORD_W-1:0] operand;
        logic [WASM_CNT_W-1:0] shift_amount;
    } wasm_req_t;

    typedef struct packed {
        logic [WASM_WORD_W-1:0] result;
        logic result_write;
        logic null_flag;
        logic aux_carry;
        logic carry_flag;
        logic null_we;
        logic aux_we;
        logic carry_we;
    } wasm_rsp_t;

endpackage

// ### design/wasm_timer.sv
`timescale 1ns/1ps
module wasm_timer
    import wasm_pkg::*;
#(
    parameter int WAIT_W = WASM_WAIT_W
) (
    input wire logic core_clk, // CPU clock
    input wire logic nrst, // Async reset, active low
    input wire logic start, // Issue pulse
    input wire logic [3:0] clocks, // Listed clock count
    input wire logic ram_fetch, // Code runs from internal RAM
    output logic busy, // Instruction in flight
    output logic done // Final clock of the instruction
);
    logic [WAIT_W:0] left_reg;
    logic [WAIT_W:0] left_next;
    logic [WAIT_W:0] load;

    always_comb begin
        // RAM fetch takes the worst case so results never come early
        if (ram_fetch) begin
            load = (WAIT_W+1)'({clocks, 1'b0}) + (WAIT_W+1)'(WASM_RAM_FETCH_EXTRA);
        end else begin
            load = (WAIT_W+1)'(clocks);
        end
        left_next = left_reg;
        if (start) begin
            left_next = load - 1'b1;
        end else if (left_reg != '0) begin
            left_next = left_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            left_reg <= '0;
        end else begin
            left_reg <= left_next;
        end
    end

    assign busy = start || (left_reg != '0);
    assign done = (start && load == (WAIT_W+1)'(1)) || (!start && left_reg == (WAIT_W+1)'(1));
endmodule

// ### design/wasm_core.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01: word_sum adds operand into accumulator_pair, carry out
// RULE_02: word_difference subtracts, borrow to carry, flags updated
// RULE_03: word_compare sets flags, accumulator_pair unchanged
// RULE_04: unsigned_product: accumulator times X into pair
// RULE_05: byte_plus_one: null and aux updated, carry kept
// RULE_06: byte_minus_one: null and aux updated, carry kept
// RULE_07: word plus/minus one leave all flags
// RULE_08: byte inc/dec: 1 reg, 2 mem, 3 segment
// RULE_09: logical_right_byte: bit0 to carry, zero fill
// RULE_10: logical_right_word: bit0 to carry, zero fill
// RULE_11: left_byte_shift: bit7 to carry, zero fill
// RULE_12: left_word_shift: bit15 to carry, zero fill
// RULE_13: arith_right_byte keeps sign bit, bit0 carry
// RULE_14: arith_right_word replicates sign, bit0 carry
// RULE_15: shifts use immediate count, one clock
// RULE_16: word ALU: 1 clock, program memory 4
// RULE_17: segment word ALU: 2 clocks, program 5
// RULE_18: counts are CPU clock cycles
// RULE_19: RAM fetch: up to twice plus three
// RULE_20: null on zero; carry is carry/borrow
module wasm_core
    import wasm_pkg::*;
#(
    parameter int BYTE_W = WASM_BYTE_W,
    parameter int WORD_W = WASM_WORD_W
) (
    input wire logic core_clk, // CPU clock, 250 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic issue, // One-cycle request strobe
    input wire wasm_pkg::wasm_req_t req, // Operation, operand, count
    input wire logic [WORD_W-1:0] acc_pair_in, // Accumulator pair value
    input wire logic [BYTE_W-1:0] x_in, // X register value
    input wire logic carry_in, // Current carry flag
    output logic busy, // Instruction executing
    output logic done, // Result valid this cycle
    output wasm_pkg::wasm_rsp_t rsp // Registered result and flags
);
    import wasm_pkg::*;

    wasm_rsp_t rsp_reg;
    wasm_rsp_t rsp_next;
    wasm_rsp_t calc;
    logic [3:0] clocks;
    logic timer_done;

    function automatic logic [WORD_W:0] add_w(input logic [WORD_W-1:0] a,
                                            input logic [WORD_W-1:0] b);
        add_w = {1'b0, a} + {1'b0, b};
    endfunction

    // Borrow appears as the top bit of the widened difference
    function automatic logic [WORD_W:0] sub_w(input logic [WORD_W-1:0] a,
                                            input logic [WORD_W-1:0] b);
        sub_w = {1'b0, a} - {1'b0, b};
    endfunction

    // Aux carry comes out of bit 3 for both byte and word forms
    function automatic logic aux_of(input logic [3:0] a, input logic [3:0] b, input logic sub);
        logic [4:0] t;
        t = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        aux_of = t[4];
    endfunction

    always_comb begin
        // Clock count by operand location
        clocks = WASM_CLK_ONE; // RULE_18
        case (req.op)
            WASM_OP_WORD_SUM, WASM_OP_WORD_DIFFERENCE, WASM_OP_WORD_COMPARE: begin
                case (req.loc)
                    WASM_LOC_PROG_MEM: clocks = WASM_CLK_FOUR; // RULE_16
                    WASM_LOC_SEG_DATA: clocks = WASM_CLK_TWO; // RULE_17
                    WASM_LOC_SEG_PROG: clocks = WASM_CLK_FIVE; // RULE_17
                    default: clocks = WASM_CLK_ONE; // RULE_16
                endcase
            end
            WASM_OP_BYTE_PLUS_ONE, WASM_OP_BYTE_MINUS_ONE,
            WASM_OP_WORD_PLUS_ONE, WASM_OP_WORD_MINUS_ONE: begin
                case (req.loc)
                    WASM_LOC_REG: clocks = WASM_CLK_ONE; // RULE_08
                    WASM_LOC_SEG_DATA, WASM_LOC_SEG_PROG: clocks = WASM_CLK_THREE; // RULE_08
                    default: clocks = WASM_CLK_TWO; // RULE_08
                endcase
            end
            default: clocks = WASM_CLK_ONE; // RULE_15
        endcase
    end

    always_comb begin
        logic [WORD_W:0] w;
        logic [BYTE_W:0] b;
        logic [BYTE_W-1:0] acc_b;
        logic [WORD_W-1:0] sh;
        logic c;
        w = '0;
        b = '0;
        acc_b = acc_pair_in[WORD_W-1:BYTE_W];
        sh = '0;
        c = carry_in;
        calc = '0;
        calc.carry_flag = carry_in;
        case (req.op)
            WASM_OP_WORD_SUM: begin
                w = add_w(acc_pair_in, req.operand); // RULE_01
                calc.result = w[WORD_W-1:0];
                calc.result_write = 1'b1;
                calc.carry_flag = w[WORD_W]; // RULE_20
                calc.aux_carry = aux_of(acc_pair_in[3:0], req.operand[3:0], 1'b0);
                calc.null_flag = (w[WORD_W-1:0] == '0); // RULE_20
                {calc.null_we, calc.aux_we, calc.carry_we} = 3'h7;
            end
            WASM_OP_WORD_DIFFERENCE, WASM_OP_WORD_COMPARE: begin
                w = sub_w(acc_pair_in, req.operand); // RULE_02
                calc.result = w[WORD_W-1:0];
                // Compare only touches flags
                calc.result_write = (req.op == WASM_OP_WORD_DIFFERENCE); // RULE_03
                calc.carry_flag = w[WORD_W]; // RULE_20
                calc.aux_carry = aux_of(acc_pair_in[3:0], req.operand[3:0], 1'b1);
                calc.null_flag = (w[WORD_W-1:0] == '0); // RULE_20
                {calc.null_we, calc.aux_we, calc.carry_we} = 3'h7;
            end
            WASM_OP_UNSIGNED_PRODUCT: begin
                calc.result = {{BYTE_W{1'b0}}, acc_b} * {{BYTE_W{1'b0}}, x_in}; // RULE_04
                calc.result_write = 1'b1;
            end
            WASM_OP_BYTE_PLUS_ONE, WASM_OP_BYTE_MINUS_ONE: begin
                // Byte target rides in the operand's low byte
                if (req.op == WASM_OP_BYTE_PLUS_ONE) begin
                    b = {1'b0, req.operand[BYTE_W-1:0]} + 9'h001; // RULE_05
                end else begin
                    b = {1'b0, req.operand[BYTE_W-1:0]} - 9'h001; // RULE_06
                end
                calc.result = {{BYTE_W{1'b0}}, b[BYTE_W-1:0]};
                calc.result_write = 1'b1;
                calc.aux_carry = aux_of(req.operand[3:0], 4'h1,
                                        req.op == WASM_OP_BYTE_MINUS_ONE);
                calc.null_flag = (b[BYTE_W-1:0] == '0); // RULE_20
                {calc.null_we, calc.aux_we, calc.carry_we} = 3'h6; // RULE_05 RULE_06
            end
            WASM_OP_WORD_PLUS_ONE, WASM_OP_WORD_MINUS_ONE: begin
                if (req.op == WASM_OP_WORD_PLUS_ONE) begin
                    calc.result = req.operand + 16'h0001; // RULE_07
                end else begin
                    calc.result = req.operand - 16'h0001; // RULE_07
                end
                calc.result_write = 1'b1;
            end
            WASM_OP_LOGICAL_RIGHT_BYTE, WASM_OP_ARITH_RIGHT_BYTE: begin
                // Whole count in one clock through a barrel shift
                sh = {{BYTE_W{1'b0}}, acc_b};
                for (int i = 0; i < 15; i++) begin
                    if (i < int'(req.shift_amount)) begin
                        c = sh[0]; // RULE_09 RULE_13
                        sh[BYTE_W-1:0] = {(req.op == WASM_OP_ARITH_RIGHT_BYTE) && sh[BYTE_W-1],
                                          sh[BYTE_W-1:1]}; // RULE_09 RULE_13
                    end
                end
                calc.result = sh;
                calc.result_write = 1'b1;
                calc.carry_flag = c;
                calc.carry_we = 1'b1;
            end
            WASM_OP_LOGICAL_RIGHT_WORD, WASM_OP_ARITH_RIGHT_WORD: begin
                sh = acc_pair_in;
                for (int i = 0; i < 15; i++) begin
                    if (i < int'(req.shift_amount)) begin
                        c = sh[0]; // RULE_10 RULE_14
                        sh = {(req.op == WASM_OP_ARITH_RIGHT_WORD) && sh[WORD_W-1],
                              sh[WORD_W-1:1]}; // RULE_10 RULE_14
                    end
                end
                calc.result = sh;
                calc.result_write = 1'b1;
                calc.carry_flag = c;
                calc.carry_we = 1'b1;
            end
            WASM_OP_LEFT_BYTE_SHIFT: begin
                // Source byte (A, B or C) is delivered in the operand's low byte
                sh = {{BYTE_W{1'b0}}, req.operand[BYTE_W-1:0]};
                for (int i = 0; i < 15; i++) begin
                    if (i < int'(req.shift_amount)) begin
                        c = sh[BYTE_W-1]; // RULE_11
                        sh[BYTE_W-1:0] = {sh[BYTE_W-2:0], 1'b0}; // RULE_11
                    end
                end
                calc.result = sh;
                calc.result_write = 1'b1;
                calc.carry_flag = c;
                calc.carry_we = 1'b1;
            end
            WASM_OP_LEFT_WORD_SHIFT: begin
                sh = req.operand;
                for (int i = 0; i < 15; i++) begin
                    if (i < int'(req.shift_amount)) begin
                        c = sh[WORD_W-1]; // RULE_12
                        sh = {sh[WORD_W-2:0], 1'b0}; // RULE_12
                    end
                end
                calc.result = sh;
                calc.result_write = 1'b1;
                calc.carry_flag = c;
                calc.carry_we = 1'b1;
            end
            default: calc = '0;
        endcase
    end

    logic busy_hold;
    logic busy_any;

    // Result is captured at an accepted issue and held until the next accepted issue
    always_comb begin
        rsp_next = rsp_reg;
        if (issue && !busy_hold) begin
            rsp_next = calc;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // Timer restarts only on an accepted issue; an issue while busy is ignored
    wasm_timer #(
        .WAIT_W(WASM_WAIT_W)
    ) u_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(issue && !busy_hold),
        .clocks(clocks),
        .ram_fetch(req.ram_fetch), // RULE_19
        .busy(busy_any),
        .done(timer_done)
    );

    logic busy_hold_reg;
    logic busy_hold_next;

    always_comb begin
        busy_hold_next = busy_any && !timer_done;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_hold_reg <= 1'b0;
        end else begin
            busy_hold_reg <= busy_hold_next;
        end
    end

    assign busy_hold = busy_hold_reg;
    assign busy = busy_any;
    // Done is timer_done registered, so it comes the clock after the last one, once busy has dropped; rsp is valid from the cycle after issue
    logic done_reg;
    logic done_next;

    always_comb begin
        done_next = timer_done;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
    assign rsp = rsp_reg;
endmodule

// ### test/wasm_core_chk.sv
`timescale 1ns/1ps
module wasm_core_chk
    import wasm_pkg::*;
(
    input wire logic core_clk, // CPU clock
    input wire logic nrst, // Async reset, active low
    input wire logic issue, // Request strobe
    input wire wasm_pkg::wasm_req_t req, // Request
    input wire logic [15:0] acc_pair_in, // Accumulator pair
    input wire logic [7:0] x_in, // X register
    input wire logic carry_in, // Carry flag
    input wire logic busy, // In flight
    input wire logic done, // Finish pulse
    input wire wasm_pkg::wasm_rsp_t rsp // Result and flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic accept, first_reg, first_next;
    logic [3:0] left_reg, left_next;
    wasm_req_t req_reg, req_next;
    logic [15:0] acc_reg, acc_next;
    logic [7:0] x_reg, x_next;

    function automatic logic [3:0] span(wasm_req_t r);
        logic [3:0] n;
        n = WASM_CLK_ONE;
        if (r.op <= WASM_OP_WORD_COMPARE) begin
            if (r.loc == WASM_LOC_PROG_MEM) n = WASM_CLK_FOUR;
            if (r.loc == WASM_LOC_SEG_DATA) n = WASM_CLK_TWO;
            if (r.loc == WASM_LOC_SEG_PROG) n = WASM_CLK_FIVE;
        end else if (r.op <= WASM_OP_WORD_MINUS_ONE && r.op >= WASM_OP_BYTE_PLUS_ONE) begin
            if (r.loc != WASM_LOC_REG) n = WASM_CLK_TWO;
            if (r.loc >= WASM_LOC_SEG_DATA) n = WASM_CLK_THREE;
        end
        return r.ram_fetch ? (n << 1) + 4'h3 : n;
    endfunction

    // A new request is legal again in the cycle where done shows
    always_comb begin
        accept = issue && (left_reg <= 4'h1);
        first_next = accept;
        req_next = accept ? req : req_reg;
        acc_next = accept ? acc_pair_in : acc_reg;
        x_next = accept ? x_in : x_reg;
        left_next = accept ? span(req) : (left_reg == 4'h0 ? 4'h0 : left_reg - 4'h1);
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= 1'b0;
            left_reg <= 4'h0;
            req_reg <= '0;
            acc_reg <= 16'h0000;
            x_reg <= 8'h00;
        end else begin
            first_reg <= first_next;
            left_reg <= left_next;
            req_reg <= req_next;
            acc_reg <= acc_next;
            x_reg <= x_next;
        end
    end

    sequence s_at4;
        !done [*3] ##1 done;
    endsequence
    sequence s_at5;
        !done [*4] ##1 done;
    endsequence
    property p_done_time;
        done == (left_reg == 4'h1);
    endproperty
    a_done_time: assert property (p_done_time) else $error("done off count");
    property p_prog_four;
        accept && req.op <= WASM_OP_WORD_COMPARE && req.loc == WASM_LOC_PROG_MEM
            && !req.ram_fetch |=> s_at4;
    endproperty
    a_prog_four: assert property (p_prog_four) else $error("program memory time");
    property p_seg_five;
        accept && req.op <= WASM_OP_WORD_COMPARE && req.loc == WASM_LOC_SEG_PROG
            && !req.ram_fetch |=> s_at5;
    endproperty
    a_seg_five: assert property (p_seg_five) else $error("segment program time");
    property p_shift_one;
        accept && req.op >= WASM_OP_LOGICAL_RIGHT_BYTE && !req.ram_fetch |=> done;
    endproperty
    a_shift_one: assert property (p_shift_one) else $error("shift not one clock");
    property p_ram_fetch;
        accept && req.op >= WASM_OP_LOGICAL_RIGHT_BYTE && req.ram_fetch |=> s_at5;
    endproperty
    a_ram_fetch: assert property (p_ram_fetch) else $error("fetch stretch");
    property p_sum;
        first_reg && req_reg.op == WASM_OP_WORD_SUM |-> rsp.carry_we
            && {rsp.carry_flag, rsp.result} == {1'b0, acc_reg} + {1'b0, req_reg.operand}
            && rsp.aux_carry == (({1'b0, acc_reg[3:0]} + {1'b0, req_reg.operand[3:0]}) > 5'h0F);
    endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");
    property p_diff;
        first_reg && (req_reg.op == WASM_OP_WORD_DIFFERENCE || req_reg.op == WASM_OP_WORD_COMPARE)
            |-> rsp.carry_flag == (acc_reg < req_reg.operand)
            && rsp.null_flag == (acc_reg == req_reg.operand)
            && rsp.result_write == (req_reg.op == WASM_OP_WORD_DIFFERENCE);
    endproperty
    a_diff: assert property (p_diff) else $error("difference flags");
    property p_product;
        first_reg && req_reg.op == WASM_OP_UNSIGNED_PRODUCT
            |-> rsp.result == {8'h00, acc_reg[15:8]} * {8'h00, x_reg} && !rsp.carry_we;
    endproperty
    a_product: assert property (p_product) else $error("product wrong");
    property p_byte_step;
        first_reg && (req_reg.op == WASM_OP_BYTE_PLUS_ONE || req_reg.op == WASM_OP_BYTE_MINUS_ONE)
            |-> !rsp.carry_we && rsp.null_we && rsp.aux_we;
    endproperty
    a_byte_step: assert property (p_byte_step) else $error("byte step flags");
    property p_word_step;
        first_reg && (req_reg.op == WASM_OP_WORD_PLUS_ONE || req_reg.op == WASM_OP_WORD_MINUS_ONE)
            |-> !(rsp.null_we || rsp.aux_we || rsp.carry_we);
    endproperty
    a_word_step: assert property (p_word_step) else $error("word step flags");
endmodule

bind wasm_core wasm_core_chk i_wasm_core_chk (.core_clk, .nrst, .issue, .req, .acc_pair_in,
    .x_in, .carry_in, .busy, .done, .rsp);

// ### test/wasm_seq_model.sv
`timescale 1ns/1ps
module wasm_seq_model
    import wasm_pkg::*;
#(
    parameter logic [7:0] X_VALUE = 8'h0C
) (
    input wire logic core_clk, // CPU clock
    input wire logic nrst, // Async reset, active low
    input wire logic load, // Bench preset of the registers
    input wire logic [15:0] load_acc, // Preset for the accumulator pair
    input wire logic done, // Instruction finished
    input wire wasm_pkg::wasm_rsp_t rsp, // Result and flag writes
    output logic [15:0] acc_pair, // Accumulator pair
    output logic [7:0] x_val, // X register
    output logic carry // Carry flag
);
    logic [15:0] acc_reg, acc_next;
    logic carry_reg, carry_next;
    // Carry preset high so a kept carry differs from a cleared one
    always_comb begin
        acc_next = load ? load_acc : acc_reg;
        carry_next = carry_reg;
        if (load) carry_next = 1'b1;
        else if (done && rsp.carry_we) carry_next = rsp.carry_flag;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acc_reg <= 16'h0000;
            carry_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            carry_reg <= carry_next;
        end
    end
    assign acc_pair = acc_reg;
    assign x_val = X_VALUE;
    assign carry = carry_reg;
endmodule

// ### test/wasm_core_tb.sv
`timescale 1ns/1ps
module wasm_core_tb;
    import wasm_pkg::*;
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] loc;
        logic rf;
        logic [15:0] opd;
        logic [3:0] sh;
        logic [15:0] acc;
        logic [15:0] res;
        logic [2:0] we;
        logic cy;
        logic z;
        logic [3:0] n;
    } wasm_row_t;
    logic core_clk, nrst, issue, load, carry_in, busy, done;
    logic [15:0] load_acc, acc_pair_in;
    logic [7:0] x_in;
    wasm_req_t req;
    wasm_rsp_t rsp;
    int err_count, comparisons;
    wasm_row_t rows [18] = '{
        '{4'h0, 3'h0, 1'h0, 16'h0001, 4'h0, 16'hFFFF, 16'h0000, 3'h7, 1'h1, 1'h1, 4'h1},
        '{4'h0, 3'h2, 1'h0, 16'h1234, 4'h0, 16'h1111, 16'h2345, 3'h7, 1'h0, 1'h0, 4'h4},
        '{4'h0, 3'h3, 1'h0, 16'h8000, 4'h0, 16'h8000, 16'h0000, 3'h7, 1'h1, 1'h1, 4'h2},
        '{4'h1, 3'h4, 1'h0, 16'h1235, 4'h0, 16'h1234, 16'hFFFF, 3'h7, 1'h1, 1'h0, 4'h5},
        '{4'h2, 3'h1, 1'h0, 16'h0002, 4'h0, 16'h0001, 16'h0000, 3'h7, 1'h1, 1'h0, 4'h1},
        '{4'h3, 3'h0, 1'h0, 16'h0000, 4'h0, 16'h1200, 16'h00D8, 3'h0, 1'h0, 1'h0, 4'h1},
        '{4'h4, 3'h0, 1'h0, 16'h00FF, 4'h0, 16'h0000, 16'h0000, 3'h6, 1'h0, 1'h1, 4'h1},
        '{4'h5, 3'h1, 1'h0, 16'h0000, 4'h0, 16'h0000, 16'h00FF, 3'h6, 1'h0, 1'h0, 4'h2},
        '{4'h4, 3'h3, 1'h0, 16'h0010, 4'h0, 16'h0000, 16'h0011, 3'h6, 1'h0, 1'h0, 4'h3},
        '{4'h6, 3'h0, 1'h0, 16'hFFFF, 4'h0, 16'h0000, 16'h0000, 3'h0, 1'h0, 1'h0, 4'h1},
        '{4'h7, 3'h1, 1'h0, 16'h0000, 4'h0, 16'h0000, 16'hFFFF, 3'h0, 1'h0, 1'h0, 4'h2},
        '{4'h8, 3'h0, 1'h0, 16'h8585, 4'h3, 16'h8585, 16'h0010, 3'h1, 1'h1, 1'h0, 4'h1},
        '{4'h9, 3'h0, 1'h0, 16'h8421, 4'h4, 16'h8421, 16'h0842, 3'h1, 1'h0, 1'h0, 4'h1},
        '{4'hA, 3'h0, 1'h0, 16'h8181, 4'h1, 16'h8181, 16'h0002, 3'h1, 1'h1, 1'h0, 4'h1},
        '{4'hB, 3'h0, 1'h0, 16'h0003, 4'hF, 16'h0003, 16'h8000, 3'h1, 1'h1, 1'h0, 4'h1},
        '{4'hC, 3'h0, 1'h0, 16'h8484, 4'h2, 16'h8484, 16'h00E1, 3'h1, 1'h0, 1'h0, 4'h1},
        '{4'hD, 3'h0, 1'h0, 16'h8001, 4'h1, 16'h8001, 16'hC000, 3'h1, 1'h1, 1'h0, 4'h1},
        '{4'h0, 3'h0, 1'h1, 16'h0001, 4'h0, 16'h0001, 16'h0002, 3'h7, 1'h0, 1'h0, 4'h5}
    };

    wasm_core i_wasm_core (.core_clk, .nrst, .issue, .req, .acc_pair_in, .x_in, .carry_in,
        .busy, .done, .rsp);
    wasm_seq_model i_wasm_seq_model (.core_clk, .nrst, .load, .load_acc, .done, .rsp,
        .acc_pair(acc_pair_in), .x_val(x_in), .carry(carry_in));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic results;
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask
    task automatic start(input wasm_req_t q, input logic [15:0] a);
        load = 1'b1;
        load_acc = a;
        @(negedge core_clk);
        load = 1'b0;
        issue = 1'b1;
        req = q;
        @(negedge core_clk);
        issue = 1'b0;
    endtask
    task automatic run(input wasm_row_t r);
        int k;
        start('{wasm_op_t'(r.op), wasm_loc_t'(r.loc), r.rf, r.opd, r.sh}, r.acc);
        k = 1;
        while (done !== 1'b1 && k < 20) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 20) begin
            err_count++;
            results();
        end
        chk16(16'(k), {12'h000, r.n}, "clocks");
        if (r.op == 4'h2) chk1(rsp.result_write, 1'b0, "write");
        else if (r.op inside {4'h4, 4'h5, 4'h8, 4'hA, 4'hC})
            chk16({8'h00, rsp.result[7:0]}, r.res, "byte");
        else chk16(rsp.result, r.res, "word");
        chk16({13'h0000, rsp.null_we, rsp.aux_we, rsp.carry_we}, {13'h0000, r.we}, "we");
        if (r.we[0]) chk1(rsp.carry_flag, r.cy, "carry");
        if (r.we[2]) chk1(rsp.null_flag, r.z, "null");
    endtask

    initial begin
        nrst = 1'b0;
        issue = 1'b0;
        load = 1'b0;
        load_acc = 16'h0000;
        req = '0;
        err_count = 0;
        comparisons = 0;
        repeat (6) @(negedge core_clk);
        chk16(rsp.result, 16'h0000, "reset result");
        chk1(done, 1'b0, "reset done");
        nrst = 1'b1;
        foreach (rows[i]) run(rows[i]);
        // Second request while busy must vanish without trace
        load = 1'b1;
        load_acc = 16'h1111;
        @(negedge core_clk);
        load = 1'b0;
        issue = 1'b1;
        req = '{WASM_OP_WORD_SUM, WASM_LOC_PROG_MEM, 1'b0, 16'h1234, 4'h0};
        @(negedge core_clk);
        // Strobe stays up so the refused request follows without a gap
        req = '{WASM_OP_WORD_DIFFERENCE, WASM_LOC_REG, 1'b0, 16'h0001, 4'h0};
        @(negedge core_clk);
        issue = 1'b0;
        @(negedge core_clk);
        chk1(busy, 1'b1, "busy held");
        @(negedge core_clk);
        chk1(done, 1'b1, "busy done");
        chk16(rsp.result, 16'h2345, "busy result");
        repeat (3) begin
            @(negedge core_clk);
            chk1(done, 1'b0, "stray done");
            chk1(busy, 1'b0, "busy idle");
        end
        start('{WASM_OP_WORD_SUM, WASM_LOC_SEG_PROG, 1'b0, 16'h0001, 4'h0}, 16'h0001);
        nrst = 1'b0;
        @(negedge core_clk);
        chk16(rsp.result, 16'h0000, "abort result");
        nrst = 1'b1;
        repeat (6) begin
            @(negedge core_clk);
            chk1(done, 1'b0, "abort done");
        end
        run(rows[1]);
        results();
    end
endmodule
